// [rtl/pdm_pkg.sv]
package pdm_pkg;
  localparam int          PDM_PORTS      = 5;
  localparam int          PDM_PINS       = 36;
  localparam int          PDM_REG_W      = 8;
  localparam int          PDM_NARROW_W   = 4;
  localparam int          PDM_NARROW_IDX = 4;
  // register indices; byte address is four times the index
  localparam logic [7:0]  PDM_P0_LO_IDX  = 8'h00;
  localparam logic [7:0]  PDM_P0_HI_IDX  = 8'h01;
  localparam logic [7:0]  PDM_P1_LO_IDX  = 8'h04;
  localparam logic [7:0]  PDM_P1_HI_IDX  = 8'h05;
  localparam logic [7:0]  PDM_P2_LO_IDX  = 8'h08;
  localparam logic [7:0]  PDM_P2_HI_IDX  = 8'h09;
  localparam logic [7:0]  PDM_P3_LO_IDX  = 8'h0c;
  localparam logic [7:0]  PDM_P3_HI_IDX  = 8'h0d;
  localparam logic [7:0]  PDM_P4_LO_IDX  = 8'h10;
  localparam logic [7:0]  PDM_P4_HI_IDX  = 8'h11;
  localparam logic [7:0]  PDM_BANK_IDX   = 8'h20;
  localparam logic [7:0]  PDM_LO_RESET   = 8'h00;
  localparam logic [7:0]  PDM_HI_RESET   = 8'hff;
  localparam logic        PDM_BANK_RESET = 1'b0;
  localparam logic [1:0]  PDM_CODE_PULL  = 2'b00;
  localparam logic [1:0]  PDM_CODE_STRG  = 2'b01;
  localparam logic [1:0]  PDM_CODE_HIZ   = 2'b10;
  localparam logic [1:0]  PDM_CODE_ODRN  = 2'b11;
endpackage

// [rtl/pdm_top.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - each pin's two-bit drive code is the high-bit register bit over the low-bit register bit at the pin's position.
// - with the output value high, code 00 pulls up resistively, 01 drives strong and 10 or 11 leave the pin floating.
// - with the output value low, codes 00, 01 and 11 drive strong low and code 10 leaves the pin floating.
// - every pin resets to code 10, high-bit registers to all ones and low-bit registers to zeros, with its input off.
// - the low-bit register sets only the code's low bit and the high-bit register only its high bit.
// - each drive register is eight bits, bit n belonging to pin n of its port.
// - the upper nibble of both port 4 registers reads back the last value seen on the data bus.
// - the drive registers answer only while register bank 1 is selected.
module pdm_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                           CORE_CLK_IN,
  input  wire logic                           RESET_IN,
  // apb slave
  input  wire logic                           PSEL_IN,
  input  wire logic                           PENABLE_IN,
  input  wire logic                           PWRITE_IN,
  input  wire logic [ADDR_W-1:0]              PADDR_IN,
  input  wire logic [31:0]                    PWDATA_IN,
  output logic      [31:0]                    PRDATA_OUT,
  output logic                                PREADY_OUT,
  output logic                                PSLVERR_OUT,
  // output values from the port data registers, pin index is port*8+bit
  input  wire logic [pdm_pkg::PDM_PINS-1:0]   PORT_OUTPUT_VALUE_IN,
  // pad controls
  output logic      [pdm_pkg::PDM_PINS-1:0]   PIN_OUT,
  output logic      [pdm_pkg::PDM_PINS-1:0]   PIN_OE_N_OUT,
  output logic      [pdm_pkg::PDM_PINS-1:0]   PIN_PULLUP_EN_OUT,
  output logic      [pdm_pkg::PDM_PINS-1:0]   PIN_INPUT_EN_OUT,
  output logic                                BANK_SELECT_OUT
);
  import pdm_pkg::*;

  // the decode needs index bits [5:0] above a two-bit byte offset
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("pdm_top: ADDR_W must lie between 8 and 32");
  end

  // register state
  logic [PDM_REG_W-1:0] lo_r   [PDM_PORTS];
  logic [PDM_REG_W-1:0] lo_nxt [PDM_PORTS];
  logic [PDM_REG_W-1:0] hi_r   [PDM_PORTS];
  logic [PDM_REG_W-1:0] hi_nxt [PDM_PORTS];
  logic                 bank_r;
  logic                 bank_nxt;
  logic [7:0]           last_bus_r;
  logic [7:0]           last_bus_nxt;
  logic [31:0]          prdata_nxt;
  logic                 pready_nxt;
  logic                 pslverr_nxt;

  // address decode
  logic [ADDR_W-3:0]    idx;
  logic [2:0]           dec_port;
  logic                 dec_half;
  logic                 dec_drive;
  logic                 dec_bank;
  logic                 dec_ok;
  logic                 setup;
  logic                 access_done;
  logic [7:0]           rd_byte;

  assign idx         = PADDR_IN[ADDR_W-1:2];
  assign dec_port    = idx[4:2];
  assign dec_half    = idx[0];
  assign dec_bank    = (PADDR_IN[1:0] == 2'h0) && (idx == (ADDR_W-2)'(PDM_BANK_IDX));
  // drive registers sit at port*4 + half; only visible in bank 1
  assign dec_drive   = (PADDR_IN[1:0] == 2'h0) && (idx[ADDR_W-3:5] == '0) && !idx[1]
                       && (dec_port < 3'(PDM_PORTS)) && bank_r;
  assign dec_ok      = dec_drive || dec_bank;
  assign setup       = PSEL_IN && !PENABLE_IN;
  assign access_done = PSEL_IN && PENABLE_IN && PREADY_OUT;

  always_comb begin
    rd_byte = 8'h00;
    if (dec_bank) begin
      rd_byte = {7'h00, bank_r};
    end else if (dec_drive) begin
      rd_byte = dec_half ? hi_r[dec_port] : lo_r[dec_port];
      if (dec_port == 3'(PDM_NARROW_IDX)) begin
        // stale bus nibble, software masks it
        rd_byte[7:4] = last_bus_r[7:4];
      end
    end
  end

  // bus answer is prepared in the setup cycle so that outputs come from flops;
  // this gives zero wait states in the access phase
  // a refused access still answers at once, so a stray address cannot hang the bus
  always_comb begin
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !dec_ok;
      prdata_nxt  = (!PWRITE_IN && dec_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_comb begin
    for (int p = 0; p < PDM_PORTS; p++) begin
      lo_nxt[p] = lo_r[p];
      hi_nxt[p] = hi_r[p];
    end
    bank_nxt     = bank_r;
    last_bus_nxt = last_bus_r;
    if (access_done) begin
      // an errored read leaves zero here, as the bus carried zero
      last_bus_nxt = PWRITE_IN ? PWDATA_IN[7:0] : PRDATA_OUT[7:0];
      if (PWRITE_IN && dec_bank) begin
        bank_nxt = PWDATA_IN[0];
      end
      if (PWRITE_IN && dec_drive) begin
        // each register owns one bit of the code only
        if (dec_half) begin
          hi_nxt[dec_port] = PWDATA_IN[7:0];
        end else begin
          lo_nxt[dec_port] = PWDATA_IN[7:0];
        end
      end
    end
    // missing pins keep their reset code
    lo_nxt[PDM_NARROW_IDX][7:4] = PDM_LO_RESET[7:4];
    hi_nxt[PDM_NARROW_IDX][7:4] = PDM_HI_RESET[7:4];
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      for (int p = 0; p < PDM_PORTS; p++) begin
        lo_r[p] <= PDM_LO_RESET;
        hi_r[p] <= PDM_HI_RESET;
      end
      bank_r      <= PDM_BANK_RESET;
      last_bus_r  <= 8'h00;
      PRDATA_OUT  <= 32'h0000_0000;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      for (int p = 0; p < PDM_PORTS; p++) begin
        lo_r[p] <= lo_nxt[p];
        hi_r[p] <= hi_nxt[p];
      end
      bank_r      <= bank_nxt;
      last_bus_r  <= last_bus_nxt;
      PRDATA_OUT  <= prdata_nxt;
      PREADY_OUT  <= pready_nxt;
      PSLVERR_OUT <= pslverr_nxt;
    end
  end

  // pad control per pin
  logic [PDM_PINS-1:0] pin_nxt;
  logic [PDM_PINS-1:0] oe_n_nxt;
  logic [PDM_PINS-1:0] pull_nxt;
  logic [PDM_PINS-1:0] inen_nxt;
  logic [1:0]          code [PDM_PINS];

  genvar g;
  generate
    for (g = 0; g < PDM_PINS; g++) begin : g_pin
      assign code[g] = {hi_r[g/8][g%8], lo_r[g/8][g%8]};
    end
  endgenerate

  // pull-up and strong drive are never on together, so a pad never fights its own resistor
  always_comb begin
    for (int p = 0; p < PDM_PINS; p++) begin
      pin_nxt[p]  = 1'b0;
      oe_n_nxt[p] = 1'b1;
      pull_nxt[p] = 1'b0;
      inen_nxt[p] = (code[p] != PDM_CODE_HIZ);
      if (PORT_OUTPUT_VALUE_IN[p]) begin
        case (code[p])
          PDM_CODE_PULL: pull_nxt[p] = 1'b1;
          PDM_CODE_STRG: begin
            pin_nxt[p]  = 1'b1;
            oe_n_nxt[p] = 1'b0;
          end
          PDM_CODE_HIZ,
          PDM_CODE_ODRN: oe_n_nxt[p] = 1'b1;
        endcase
      end else begin
        // open-drain code still sinks the low level
        oe_n_nxt[p] = (code[p] == PDM_CODE_HIZ);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      PIN_OUT           <= '0;
      PIN_OE_N_OUT      <= '1;
      PIN_PULLUP_EN_OUT <= '0;
      PIN_INPUT_EN_OUT  <= '0;
      BANK_SELECT_OUT   <= 1'b0;
    end else begin
      PIN_OUT           <= pin_nxt;
      PIN_OE_N_OUT      <= oe_n_nxt;
      PIN_PULLUP_EN_OUT <= pull_nxt;
      PIN_INPUT_EN_OUT  <= inen_nxt;
      BANK_SELECT_OUT   <= bank_nxt;
    end
  end

  // checks; pad checks run on every pin so that whichever pin the bench drives is covered
  generate
    for (g = 0; g < PDM_PINS; g++) begin : g_pin_chk
      pull_when_high_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (PORT_OUTPUT_VALUE_IN[g] && code[g] == PDM_CODE_PULL) |=> (PIN_PULLUP_EN_OUT[g] && PIN_OE_N_OUT[g]))
        else $error("pin not pulled up for code 00 high");

      strong_high_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (PORT_OUTPUT_VALUE_IN[g] && code[g] == PDM_CODE_STRG) |=> (!PIN_OE_N_OUT[g] && PIN_OUT[g]))
        else $error("pin not driven high for code 01");

      open_drain_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (PORT_OUTPUT_VALUE_IN[g] && code[g] == PDM_CODE_ODRN) |=> (PIN_OE_N_OUT[g] && !PIN_PULLUP_EN_OUT[g]))
        else $error("pin not released for code 11 high");

      strong_low_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (!PORT_OUTPUT_VALUE_IN[g] && code[g] != PDM_CODE_HIZ) |=> (!PIN_OE_N_OUT[g] && !PIN_OUT[g]))
        else $error("pin not driven low");

      hiz_low_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (code[g] == PDM_CODE_HIZ) |=> (PIN_OE_N_OUT[g] && !PIN_PULLUP_EN_OUT[g] && !PIN_INPUT_EN_OUT[g]))
        else $error("pin not floating for code 10");

      input_on_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (code[g] != PDM_CODE_HIZ) |=> PIN_INPUT_EN_OUT[g])
        else $error("pin input off outside code 10");

      pin_quiet_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        !(PORT_OUTPUT_VALUE_IN[g] && code[g] == PDM_CODE_STRG) |=> !PIN_OUT[g])
        else $error("pin data high without strong high drive");
    end
  endgenerate

  reset_code_a: assert property (@(posedge CORE_CLK_IN)
    $fell(RESET_IN) |-> (hi_r[2] == 8'hff && lo_r[2] == 8'h00 && PIN_OE_N_OUT == '1))
    else $error("drive registers not at reset code");

  write_low_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (access_done && PWRITE_IN && dec_drive && !dec_half && dec_port == 3'd1)
      |=> (lo_r[1] == $past(PWDATA_IN[7:0]) && hi_r[1] == $past(hi_r[1])))
    else $error("low-bit write wrong or touched high bits");

  stale_nibble_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (setup && !PWRITE_IN && dec_drive && dec_port == 3'd4)
      |=> (PRDATA_OUT[7:4] == $past(last_bus_r[7:4]) && PRDATA_OUT[3:0] == $past(rd_byte[3:0])))
    else $error("port 4 upper nibble not last bus value");

  bank_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (setup && !bank_r && !dec_bank) |=> (PSLVERR_OUT && PRDATA_OUT == 32'h0))
    else $error("drive register reachable outside bank 1");

  write_high_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (access_done && PWRITE_IN && dec_drive && dec_half && dec_port == 3'd1)
      |=> (hi_r[1] == $past(PWDATA_IN[7:0]) && lo_r[1] == $past(lo_r[1])))
    else $error("high-bit write wrong or touched low bits");

  error_write_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (access_done && PWRITE_IN && !dec_ok)
      |=> (lo_r[1] == $past(lo_r[1]) && hi_r[1] == $past(hi_r[1])))
    else $error("refused write changed a drive register");

  bank_out_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    BANK_SELECT_OUT == bank_r)
    else $error("bank select output differs from bank bit");

  bank_read_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (setup && !PWRITE_IN && dec_bank) |=> (PRDATA_OUT == {31'h0, $past(bank_r)} && !PSLVERR_OUT))
    else $error("bank read data wrong");

  misalign_err_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (setup && PADDR_IN[1:0] != 2'h0) |=> (PSLVERR_OUT && PRDATA_OUT == 32'h0))
    else $error("misaligned access not refused");

  read_upper_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    PREADY_OUT |-> (PRDATA_OUT[31:8] == 24'h0))
    else $error("read data above bit 7 not zero");

  ready_setup_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    setup |=> PREADY_OUT)
    else $error("no answer in the first access cycle");

  narrow_fixed_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (lo_r[4][7:4] == 4'h0) && (hi_r[4][7:4] == 4'hf))
    else $error("port 4 upper nibble changed");

  ready_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    PREADY_OUT |=> !PREADY_OUT)
    else $error("pready held longer than one cycle");
endmodule

// [testbench/port_pin_drive_mode_select_tb_top.sv]
`timescale 1ns/1ns
module port_pin_drive_mode_select_tb_top;
  import pdm_pkg::*;
  logic                clk     = 1'b0;
  logic                rst     = 1'b1;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [11:0]         paddr   = 12'h000;
  logic [31:0]         pwdata  = 32'h0;
  logic [PDM_PINS-1:0] val     = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [PDM_PINS-1:0] pin;
  logic [PDM_PINS-1:0] oe_n;
  logic [PDM_PINS-1:0] pull;
  logic [PDM_PINS-1:0] inen;
  logic                bank;
  logic [31:0]         rd;
  logic                er;
  logic [1:0]          code;
  logic                exp_oen;
  int                  num_errors = 0;
  int                  num_checks = 0;

  always #5 clk = ~clk;

  pdm_top #(.ADDR_W(12)) DUT (
    .CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PORT_OUTPUT_VALUE_IN(val), .PIN_OUT(pin), .PIN_OE_N_OUT(oe_n), .PIN_PULLUP_EN_OUT(pull),
    .PIN_INPUT_EN_OUT(inen), .BANK_SELECT_OUT(bank)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {35'h0, exp}, {35'h0, got});
  endtask

  // one transfer; the request is held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("wrong value pready expected 1 seen %b", pready);
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk("read data", {4'h0, exp}, {4'h0, rd});
    chk1("slave error", eerr, er);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("oe_n after reset", '1, oe_n);
    chk("pullup after reset", '0, pull);
    chk("input en after reset", '0, inen);
    $display("test reset done");
    rchk(12'h000, 32'h0, 1'b1);
    apb(1'b0, 12'h080, 32'h0);
    chk1("bank sel", 1'b0, bank);
    apb(1'b1, 12'h080, 32'h1);
    rchk(12'h080, 32'h1, 1'b0);
    for (int p = 0; p < 4; p++) begin
      rchk(12'(p * 16), {24'h0, PDM_LO_RESET}, 1'b0);
      rchk(12'(p * 16 + 4), {24'h0, PDM_HI_RESET}, 1'b0);
    end
    // upper nibble of port 4 echoes the previous transfer's data
    rchk(12'h044, 32'hff, 1'b0);
    rchk(12'h040, 32'hf0, 1'b0);
    rchk(12'h008, 32'h0, 1'b1);
    rchk(12'h001, 32'h0, 1'b1);
    $display("test registers done");
    apb(1'b1, 12'h040, 32'h5a);
    rchk(12'h040, 32'h5a, 1'b0);
    rchk(12'h000, 32'h0, 1'b0);
    rchk(12'h040, 32'h0a, 1'b0);
    chk("port4 oe_n", {32'h0, 4'b0101}, {32'h0, oe_n[35:32]});
    $display("test port4 done");
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        code = 2'(c);
        apb(1'b1, 12'h014, {29'h0, code[1], 2'b00});
        apb(1'b1, 12'h010, {29'h0, code[0], 2'b00});
        val <= {PDM_PINS{v[0]}};
        repeat (2) @(posedge clk);
        exp_oen = (code == PDM_CODE_HIZ) || (v[0] && code != PDM_CODE_STRG);
        chk1("oe_n", exp_oen, oe_n[10]);
        if (!exp_oen) begin
          chk1("pin", v[0], pin[10]);
        end
        chk1("pullup", code == PDM_CODE_PULL && v[0], pull[10]);
        chk1("input en", code != PDM_CODE_HIZ, inen[10]);
        chk1("neighbour oe_n", v[0], oe_n[11]);
      end
    end
    $display("test drive codes done");
    apb(1'b1, 12'h080, 32'h0);
    apb(1'b1, 12'h010, 32'hff);
    chk1("bank 0 write error", 1'b1, er);
    apb(1'b1, 12'h080, 32'h1);
    rchk(12'h010, 32'h04, 1'b0);
    $display("test bank done");
    report_and_stop();
  end
endmodule
